// [hw/tsfr_map.vh]
// Constants of the temperature sensor register bank: offsets, fields, codes and timing.
// Behaviour
// - All temperatures (three trip thresholds and the reading) are twos complement.
// - Trip registers hold the threshold in bits 12:2, bit 12 sign, 0.25 degree step.
// - Reading register holds temperature in bits 12:1, lowest bit 0.125 degree.
// - Bit 12 sign, bit 11 128 degrees, halving downward, bit 1 0.125, bit 0 unused.
// - Read-only maker code register at pointer 06h.
// - Read-only register at 07h: part code high byte, revision low byte.
// - Register 22h bit 7 disables bus timeout when one; zero (default) enables it.
// - Bus timeout applies only to transactions addressed to the sensor function.
// - Timeout-disable bit writes ignored while critical or window lock is set.
// - Bits 15:8 and 6:0 of the timeout control register read zero.
// - Host writes pointer after device address; next two bytes go to that register.
// - Bytes travel MSB first; device accepts ACK or NACK after the last read byte.
`ifndef TSFR_MAP_VH
`define TSFR_MAP_VH

// Pointer values.
`define TS_PTR_UPPER 8'h02
`define TS_PTR_LOWER 8'h03
`define TS_PTR_CRIT 8'h04
`define TS_PTR_TEMP 8'h05
`define TS_PTR_MAKER 8'h06
`define TS_PTR_PART 8'h07
`define TS_PTR_TIMEOUT 8'h22

// Field positions.
`define TS_TRIP_HI 12
`define TS_TRIP_LO 2
`define TS_TEMP_HI 12
`define TS_TEMP_LO 1
`define TS_TOUT_BIT 7

// Reset values and fixed codes; identification values are arbitrary.
`define TS_RST_TRIP 11'h000
`define TS_RST_TOUT 1'b0
`define TS_MAKER_CODE 16'h0a5c
`define TS_PART_CODE 8'h3c
`define TS_REV_CODE 8'h01

// Bus constants.
`define TS_DEV_TYPE 4'h3
`define TS_LAST_BIT 3'h7
`define TS_ZERO16 16'h0000

// Timeout length in clock cycles: 25 ms at the 125 MHz clock, sized to the counter.
`define TS_TIMEOUT_CYC 24'd3125000

`endif

// [hw/tsfr_sync.v]
// Two-flop synchroniser for pin inputs, one stage pair per bit.
`timescale 1ns/1ps
`default_nettype none
module tsfr_sync #(
  parameter WIDTH = 5
) (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Asynchronous inputs and their synchronised copies.
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gStage
      reg meta_r;
      reg stable_r;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r <= 1'b1;
          stable_r <= 1'b1;
        end else begin
          meta_r <= asyncIn[i];
          stable_r <= meta_r;
        end
      end
      assign syncOut[i] = stable_r;
    end
  endgenerate

endmodule
`default_nettype wire

// [hw/tsfr_regs.v]
// Temperature sensor register bank behind a two-wire serial slave.
`timescale 1ns/1ps
`default_nettype none
`include "tsfr_map.vh"
module tsfr_regs #(
  parameter [23:0] TIMEOUT_CYCLES = `TS_TIMEOUT_CYC
) (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Serial pins.
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  input wire [2:0] addrPins,
  // Measurement engine, same clock.
  input wire [11:0] tempReading,
  input wire [2:0] tripStatus,
  // Lock bits from the configuration logic, same clock.
  input wire critLockIn,
  input wire windowLockIn,
  // Thresholds and timeout control toward the rest of the sensor.
  output wire [10:0] upperThresh,
  output wire [10:0] lowerThresh,
  output wire [10:0] critThresh,
  output wire timeoutDisable
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ACKA = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_ACKP = 4'h4;
  localparam [3:0] ST_WRD = 4'h5;
  localparam [3:0] ST_ACKW = 4'h6;
  localparam [3:0] ST_RD = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;
  localparam [3:0] ST_WAIT = 4'h9;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus event detection.

  wire [4:0] syncBits;
  wire sclS;
  wire sdaS;
  wire [2:0] addrS;
  reg sclD_r;
  reg sdaD_r;

  tsfr_sync #(
    .WIDTH(5)
  ) uSync (
    .clk(clk),
    .arst_n(arst_n),
    .asyncIn({addrPins, sdaIn, sclIn}),
    .syncOut(syncBits)
  );

  assign sclS = syncBits[0];
  assign sdaS = syncBits[1];
  assign addrS = syncBits[4:2];

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
    end
  end

  wire startEv = sclS && sclD_r && sdaD_r && !sdaS;
  wire stopEv = sclS && sclD_r && !sdaD_r && sdaS;
  wire sclRise = sclS && !sclD_r;
  wire sclFall = !sclS && sclD_r;

  //////////////////////////////////////////////////////////////////////////////
  // Registers and read data.

  reg [3:0] state_r;
  reg [2:0] bitCnt_r;
  reg byteDone_r;
  reg [7:0] shift_r;
  reg [7:0] ptr_r;
  reg [7:0] wrHi_r;
  reg byteIdx_r;
  reg sdaOe_r;
  reg sdaOut_r;
  reg [10:0] upper_r;
  reg [10:0] lower_r;
  reg [10:0] crit_r;
  reg toutDis_r;
  reg [23:0] toutCnt_r;
  reg [15:0] rdData;

  // Reading and thresholds are carried as raw twos complement; no conversion.
  always @* begin
    case (ptr_r)
      `TS_PTR_UPPER: rdData = {3'h0, upper_r, 2'h0};
      `TS_PTR_LOWER: rdData = {3'h0, lower_r, 2'h0};
      `TS_PTR_CRIT: rdData = {3'h0, crit_r, 2'h0};
      `TS_PTR_TEMP: rdData = {tripStatus, tempReading, 1'b0};
      `TS_PTR_MAKER: rdData = `TS_MAKER_CODE;
      `TS_PTR_PART: rdData = {`TS_PART_CODE, `TS_REV_CODE};
      `TS_PTR_TIMEOUT: rdData = {8'h00, toutDis_r, 7'h00};
      default: rdData = `TS_ZERO16;
    endcase
  end

  wire [15:0] wrWord = {wrHi_r, shift_r};
  wire addrMatch = (shift_r[7:1] == {`TS_DEV_TYPE, addrS});
  wire [7:0] nextByte = byteIdx_r ? rdData[15:8] : rdData[7:0];
  // Only an addressed transaction counts as busy, so the timeout never cuts other functions.
  wire busy = (state_r != ST_IDLE) && (state_r != ST_WAIT) && (state_r != ST_ADDR);
  wire toutHit = !toutDis_r && busy && !sclS && (toutCnt_r >= TIMEOUT_CYCLES);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      toutCnt_r <= 24'h000000;
    end else if (busy && !sclS && !toutDis_r) begin
      toutCnt_r <= toutCnt_r + 24'h000001;
    end else begin
      toutCnt_r <= 24'h000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial slave state machine.

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 3'h0;
      byteDone_r <= 1'b0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      wrHi_r <= 8'h00;
      byteIdx_r <= 1'b0;
      sdaOe_r <= 1'b0;
      sdaOut_r <= 1'b0;
      upper_r <= `TS_RST_TRIP;
      lower_r <= `TS_RST_TRIP;
      crit_r <= `TS_RST_TRIP;
      toutDis_r <= `TS_RST_TOUT;
    end else if (startEv) begin
      state_r <= ST_ADDR;
      bitCnt_r <= 3'h0;
      byteDone_r <= 1'b0;
      byteIdx_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else if (stopEv || toutHit) begin
      state_r <= ST_IDLE;
      sdaOe_r <= 1'b0;
    end else if (sclRise) begin
      case (state_r)
        ST_ADDR, ST_PTR, ST_WRD, ST_RD: begin
          if (state_r != ST_RD) begin
            shift_r <= {shift_r[6:0], sdaS};
          end
          bitCnt_r <= bitCnt_r + 3'h1;
          byteDone_r <= (bitCnt_r == `TS_LAST_BIT);
        end
        ST_RACK: begin
          // A not-acknowledge ends the read cleanly; an acknowledge asks for more.
          if (sdaS) begin
            state_r <= ST_WAIT;
          end
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end else if (sclFall) begin
      case (state_r)
        ST_ADDR: begin
          if (byteDone_r) begin
            byteDone_r <= 1'b0;
            if (addrMatch) begin
              sdaOe_r <= 1'b1;
              byteIdx_r <= shift_r[0];
              state_r <= ST_ACKA;
            end else begin
              state_r <= ST_WAIT;
            end
          end
        end
        ST_ACKA: begin
          if (byteIdx_r) begin
            shift_r <= rdData[15:8];
            sdaOe_r <= !rdData[15];
            byteIdx_r <= 1'b0;
            state_r <= ST_RD;
          end else begin
            sdaOe_r <= 1'b0;
            state_r <= ST_PTR;
          end
        end
        ST_PTR: begin
          if (byteDone_r) begin
            byteDone_r <= 1'b0;
            ptr_r <= shift_r;
            sdaOe_r <= 1'b1;
            state_r <= ST_ACKP;
          end
        end
        ST_ACKP: begin
          sdaOe_r <= 1'b0;
          byteIdx_r <= 1'b0;
          state_r <= ST_WRD;
        end
        ST_WRD: begin
          if (byteDone_r) begin
            byteDone_r <= 1'b0;
            sdaOe_r <= 1'b1;
            state_r <= ST_ACKW;
            if (!byteIdx_r) begin
              wrHi_r <= shift_r;
            end else begin
              // Identification and reading registers take no write but still acknowledge.
              case (ptr_r)
                `TS_PTR_UPPER: begin
                  if (!windowLockIn) begin
                    upper_r <= wrWord[`TS_TRIP_HI:`TS_TRIP_LO];
                  end
                end
                `TS_PTR_LOWER: begin
                  if (!windowLockIn) begin
                    lower_r <= wrWord[`TS_TRIP_HI:`TS_TRIP_LO];
                  end
                end
                `TS_PTR_CRIT: begin
                  if (!critLockIn) begin
                    crit_r <= wrWord[`TS_TRIP_HI:`TS_TRIP_LO];
                  end
                end
                `TS_PTR_TIMEOUT: begin
                  if (!critLockIn && !windowLockIn) begin
                    toutDis_r <= wrWord[`TS_TOUT_BIT];
                  end
                end
                default: begin
                  wrHi_r <= wrHi_r;
                end
              endcase
            end
          end
        end
        ST_ACKW: begin
          sdaOe_r <= 1'b0;
          // Bytes past the second are not acknowledged, so the host sees the end.
          if (byteIdx_r) begin
            state_r <= ST_WAIT;
          end else begin
            byteIdx_r <= 1'b1;
            state_r <= ST_WRD;
          end
        end
        ST_RD: begin
          if (byteDone_r) begin
            byteDone_r <= 1'b0;
            sdaOe_r <= 1'b0;
            state_r <= ST_RACK;
          end else begin
            shift_r <= {shift_r[6:0], 1'b0};
            sdaOe_r <= !shift_r[6];
          end
        end
        ST_RACK: begin
          // Further acknowledged reads alternate low and high byte of the same register.
          byteIdx_r <= !byteIdx_r;
          shift_r <= byteIdx_r ? rdData[15:8] : rdData[7:0];
          sdaOe_r <= !nextByte[7];
          state_r <= ST_RD;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign sdaOut = sdaOut_r;
  assign sdaOe = sdaOe_r;
  assign upperThresh = upper_r;
  assign lowerThresh = lower_r;
  assign critThresh = crit_r;
  assign timeoutDisable = toutDis_r;

endmodule
`default_nettype wire

// [test/tsfr_regs_sva.sv]
// Checker for the sensor register bank, bound to its ports.
`timescale 1ns/1ps
`default_nettype none
module tsfr_regs_sva #(
  parameter [23:0] TIMEOUT_CYCLES = 24'd200
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Bus pins.
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [2:0] addrPins,
  // Sensor side.
  input wire logic [11:0] tempReading,
  input wire logic [2:0] tripStatus,
  input wire logic critLockIn,
  input wire logic windowLockIn,
  input wire logic [10:0] upperThresh,
  input wire logic [10:0] lowerThresh,
  input wire logic [10:0] critThresh,
  input wire logic timeoutDisable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Low time seen at the pin; the slack covers the synchroniser delay.
  logic [23:0] lowCnt_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) lowCnt_r <= 24'h0;
    else lowCnt_r <= sclIn ? 24'h0 : lowCnt_r + 24'h1;
  end
  sequence s_sclHigh;
    sclIn [*6];
  endsequence
  a_open_drain: assert property (sdaOut == 1'b0) else $error("sda driven high");
  a_oe_steady: assert property (s_sclHigh |-> $stable(sdaOe))
    else $error("sda moved under high scl");
  a_oe_rise_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("sda taken under high scl");
  a_lock_hold: assert property (critLockIn || windowLockIn |=> $stable(timeoutDisable))
    else $error("locked bit changed");
  a_tout_release: assert property (!timeoutDisable && lowCnt_r > TIMEOUT_CYCLES + 24'd16
    |-> !sdaOe) else $error("timeout did not release sda");
  a_tdis_commit: assert property ($changed(timeoutDisable) |-> !sclIn && !$past(sclIn, 2))
    else $error("timeout bit changed outside ack");
  a_trip_commit: assert property ($changed({upperThresh, lowerThresh, critThresh})
    |-> !sclIn && !$past(sclIn, 2)) else $error("threshold changed outside ack");
  a_reset_quiet: assert property (disable iff (1'b0) !arst_n
    |-> !sdaOe && !timeoutDisable && critThresh == 11'h0) else $error("reset state wrong");
endmodule
bind tsfr_regs tsfr_regs_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) tsfr_regs_sva_inst (
  .clk(clk), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .addrPins(addrPins), .tempReading(tempReading), .tripStatus(tripStatus),
  .critLockIn(critLockIn), .windowLockIn(windowLockIn), .upperThresh(upperThresh),
  .lowerThresh(lowerThresh), .critThresh(critThresh), .timeoutDisable(timeoutDisable));
`default_nettype wire

// [test/tsfr_host.sv]
// Two-wire host model issuing register reads and writes.
`timescale 1ns/1ps
`default_nettype none
`include "tsfr_map.vh"
module tsfr_host #(
  parameter logic [2:0] STRAP = 3'h5
) (
  // Clock and wire.
  input wire logic clk,
  input wire logic sda,
  // Host drives.
  output logic scl = 1'b1,
  output logic pull = 1'b0
);
  localparam int H = 8;
  int missed = 0;
  logic [7:0] extra;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // A long low phase s lets the device timeout be exercised.
  task automatic bit1(input logic b, input int s, output logic r);
    tick(H / 2 + s);
    pull <= !b;
    tick(H / 2);
    scl <= 1'b1;
    tick(H);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic edgeSda(input logic a, input logic b);
    tick(H / 2);
    pull <= a;
    tick(H / 2);
    scl <= 1'b1;
    tick(H);
    pull <= b;
    tick(H);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ackIn, input int s,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit1(d[i], 0, q[i]);
    bit1(ackIn, s, ack);
  endtask
  task automatic head(input logic [7:0] p, input int s);
    logic [7:0] q;
    logic a;
    edgeSda(1'b0, 1'b1);
    scl <= 1'b0;
    xfer({`TS_DEV_TYPE, STRAP, 1'b0}, 1'b1, 0, q, a);
    missed += (a !== 1'b0);
    xfer(p, 1'b1, s, q, a);
    missed += (a !== 1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v, input int s);
    logic [7:0] q;
    logic a;
    head(p, s);
    for (int i = 1; i >= 0 && s == 0; i--) begin
      xfer(v[i*8+:8], 1'b1, 0, q, a);
      missed += (a !== 1'b0);
    end
    edgeSda(1'b1, 1'b0);
  endtask
  task automatic rd(input logic [7:0] p, input logic ext, output logic [15:0] v);
    logic a;
    head(p, 0);
    edgeSda(1'b0, 1'b1);
    scl <= 1'b0;
    xfer({`TS_DEV_TYPE, STRAP, 1'b1}, 1'b1, 0, extra, a);
    missed += (a !== 1'b0);
    xfer(8'hff, 1'b0, 0, v[15:8], a);
    xfer(8'hff, !ext, 0, v[7:0], a);
    if (ext) xfer(8'hff, 1'b1, 0, extra, a);
    edgeSda(1'b1, 1'b0);
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the sensor register bank.
`timescale 1ns/1ps
`default_nettype none
`include "tsfr_map.vh"
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b1;
  logic critLockIn = 1'b0;
  logic windowLockIn = 1'b0;
  logic [11:0] tempReading = 12'h000;
  logic [2:0] tripStatus = 3'h0;
  logic scl, pull, sda, sdaOut, sdaOe, timeoutDisable;
  logic [10:0] upperThresh, lowerThresh, critThresh;
  logic [15:0] v;
  logic [15:0] trip [3] = '{16'hffff, 16'h1e70, 16'h07d0};
  int numErrors = 0;
  int samplesChecked = 0;
  assign sda = !(pull || sdaOe);
  tsfr_host tsfr_host_inst (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  tsfr_regs #(.TIMEOUT_CYCLES(24'd200)) tsfr_regs_inst (.clk(clk), .arst_n(arst_n),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrPins(3'h5),
    .tempReading(tempReading), .tripStatus(tripStatus), .critLockIn(critLockIn),
    .windowLockIn(windowLockIn), .upperThresh(upperThresh), .lowerThresh(lowerThresh),
    .critThresh(critThresh), .timeoutDisable(timeoutDisable));
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] p, input logic [15:0] e);
    tsfr_host_inst.rd(p, 1'b0, v);
    cmp(v, e);
  endtask
  task automatic wrapUp();
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    numErrors++;
    wrapUp();
  end
  initial begin
    // Reset is entered by an edge so the design is cleared before the first clock.
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(`TS_PTR_TIMEOUT, 16'h0000);
    tsfr_host_inst.wr(`TS_PTR_MAKER, 16'hffff, 0);
    rchk(`TS_PTR_MAKER, `TS_MAKER_CODE);
    rchk(`TS_PTR_PART, {`TS_PART_CODE, `TS_REV_CODE});
    for (int i = 0; i < 3; i++) begin
      tsfr_host_inst.wr(8'(`TS_PTR_UPPER + i), trip[i], 0);
      rchk(8'(`TS_PTR_UPPER + i), trip[i] & 16'h1ffc);
    end
    cmp({upperThresh, lowerThresh, critThresh}, {trip[0][12:2], trip[1][12:2], trip[2][12:2]});
    @(posedge clk);
    tempReading <= 12'd798;
    tripStatus <= 3'h5;
    tsfr_host_inst.rd(`TS_PTR_TEMP, 1'b1, v);
    cmp(v, {3'h5, 12'd798, 1'b0});
    cmp(tsfr_host_inst.extra, 8'ha6);
    tsfr_host_inst.wr(`TS_PTR_TIMEOUT, 16'hffff, 0);
    rchk(`TS_PTR_TIMEOUT, 16'h0080);
    for (int l = 1; l < 3; l++) begin
      @(posedge clk);
      {critLockIn, windowLockIn} <= 2'(l);
      tsfr_host_inst.wr(`TS_PTR_TIMEOUT, 16'h0000, 0);
      cmp(timeoutDisable, 1'b1);
    end
    @(posedge clk);
    {critLockIn, windowLockIn} <= 2'h0;
    tsfr_host_inst.wr(`TS_PTR_TIMEOUT, 16'h0000, 0);
    cmp(timeoutDisable, 1'b0);
    tsfr_host_inst.wr(`TS_PTR_TEMP, 16'h0000, 300);
    cmp(tsfr_host_inst.missed, 1);
    tsfr_host_inst.wr(`TS_PTR_TIMEOUT, 16'h0080, 0);
    tsfr_host_inst.wr(`TS_PTR_TEMP, 16'h0000, 300);
    cmp(tsfr_host_inst.missed, 1);
    wrapUp();
  end
endmodule
`default_nettype wire
